//--- ipr_defines.vh
// ipr_defines.vh: shared constants of the inductive proximity readout.
// Assumes it is included by bare name from each design file.
`ifndef IPR_DEFINES_VH
`define IPR_DEFINES_VH

// ==================================================
// register addresses, 7-bit serial address space
`define IPR_ADDR_ID    7'h00
`define IPR_ADDR_UB    7'h01
`define IPR_ADDR_LB    7'h02
`define IPR_ADDR_THI_L 7'h06
`define IPR_ADDR_THI_H 7'h07
`define IPR_ADDR_TLO_L 7'h08
`define IPR_ADDR_TLO_H 7'h09
`define IPR_ADDR_MODE  7'h0A
`define IPR_ADDR_PRX_L 7'h21
`define IPR_ADDR_PRX_H 7'h22
`define IPR_ADDR_FRQ_0 7'h23
`define IPR_ADDR_FRQ_1 7'h24
`define IPR_ADDR_FRQ_2 7'h25

// ==================================================
// reset values; the identity code is arbitrary
`define IPR_ID_VALUE 8'h5A
`define IPR_RST_UB   8'h0E
`define IPR_RST_LB   8'h14
`define IPR_RST_THI  16'hFFFF
`define IPR_RST_TLO  16'h0000
`define IPR_RST_MODE 2'h3

// ==================================================
// interrupt pin modes
`define IPR_MODE_OFF  2'h0
`define IPR_MODE_WAKE 2'h1
`define IPR_MODE_COMP 2'h2
`define IPR_MODE_RDY  2'h3

// ==================================================
// pin synchroniser lanes and their idle levels
`define IPR_PIN_CS   0
`define IPR_PIN_SCLK 1
`define IPR_PIN_SDI  2
`define IPR_PIN_SENS 3
`define IPR_PIN_TB   4
`define IPR_NPINS    5
`define IPR_PIN_IDLE 5'h01

// ==================================================
// counts and codes
`define IPR_BYTE_LAST  3'h7
`define IPR_RESP_LAST  8'hBF
`define IPR_DIV_LAST   5'h1E
`define IPR_FRAC_ZERO  15'h0000
`define IPR_FULL_SCALE 16'hFFFF
`define IPR_TB_MAX     24'hFFFFFF

`endif

//--- ipr_ratio_div.v
// ipr_ratio_div.v: restoring divider, 31-bit numerator over 16-bit divisor.
// Assumes start is a one-cycle pulse and is not raised while busy.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.vh"

module ipr_ratio_div (
   // system
   input wire clk,
   input wire rst_n,
   // request
   input wire start,
   input wire [30:0] num,
   input wire [15:0] den,
   // answer
   output wire done,
   output wire [15:0] quo
);

   // ==================================================
   // state
   reg busy_q; // division in progress
   reg done_q; // one-cycle completion pulse
   reg [4:0] cnt_q; // step counter
   reg [16:0] rem_q; // partial remainder
   reg [30:0] num_q; // numerator, shifted out msb first
   reg [30:0] quo_q; // quotient, shifted in msb first
   reg [15:0] den_q; // captured divisor

   // trial subtraction of this step
   wire [16:0] trial = {rem_q[15:0], num_q[30]};
   wire ge = trial >= {1'b0, den_q};

   // ==================================================
   // one quotient bit per clock
   always @(posedge clk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 5'h00;
         rem_q <= 17'h00000;
         num_q <= 31'h00000000;
         quo_q <= 31'h00000000;
         den_q <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            // capture operands
            busy_q <= 1'b1;
            cnt_q <= 5'h00;
            rem_q <= 17'h00000;
            num_q <= num;
            den_q <= den;
         end else if (busy_q) begin
            // subtract the divisor or keep the trial
            rem_q <= ge ? (trial - {1'b0, den_q}) : trial;
            num_q <= {num_q[29:0], 1'b0};
            quo_q <= {quo_q[29:0], ge};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `IPR_DIV_LAST) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign done = done_q;
   // quotient is below 2^15 by construction of the caller
   assign quo = quo_q[15:0];

endmodule // ipr_ratio_div
`default_nettype wire

//--- ipr_readout.v
// ipr_readout.v: digital result path of the inductive proximity readout.
// Assumes the analog loop delivers its power code synchronous to clk;
// serial, sensor and timebase pins are asynchronous and slow against clk.
//
// Overview of operation
// - both results latched from one conversion
// - impedance code falls as impedance rises
// - frequency count inverse to sensor frequency
// - hysteresis comparator with high and low thresholds
// - compare each new result, drive interrupt pin
// - interrupt pin function chosen by software
// - registers reached over four-wire serial slave
// - code range spans only programmed bound window
// - below lower bound, clip at full scale
// - result low byte 0x21, high byte 0x22
// - code below 2^15 interpolates reciprocal impedance
// - unread data still pulses once per conversion
// - comparator sets above high, clears below low
// - ready mode cleared by read of 0x21
// - command byte: read bit, seven address bits
// - frequency counter timed by timebase pin
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.vh"

module ipr_readout (
   // system
   input wire clk,
   input wire rst_n,
   // serial slave port
   input wire select_low,
   input wire serial_clk,
   input wire serial_in,
   output wire serial_out,
   output wire serial_out_en,
   // resonator and timebase
   input wire sensor_osc_in,
   input wire timebase_clock_in,
   input wire [15:0] conv_power,
   // interrupt pin, active low
   output wire interrupt_out_n
);

   // ==================================================
   // pin synchronisers: three flops, level moves when 2nd and 3rd agree
   localparam [4:0] PIN_IDLE = `IPR_PIN_IDLE;
   wire [4:0] pins = {timebase_clock_in, sensor_osc_in, serial_in, serial_clk, select_low};
   reg [4:0] s1_q; // first stage, read by second stage only
   reg [4:0] s2_q; // second stage
   reg [4:0] s3_q; // third stage
   reg [4:0] lvl_q; // accepted level
   reg [4:0] prv_q; // accepted level one clock ago

   genvar gi;
   generate
      for (gi = 0; gi < `IPR_NPINS; gi = gi + 1) begin : g_sync
         // one lane per pin
         always @(posedge clk) begin
            if (!rst_n) begin
               s1_q[gi] <= PIN_IDLE[gi];
               s2_q[gi] <= PIN_IDLE[gi];
               s3_q[gi] <= PIN_IDLE[gi];
               lvl_q[gi] <= PIN_IDLE[gi];
               prv_q[gi] <= PIN_IDLE[gi];
            end else begin
               s1_q[gi] <= pins[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  lvl_q[gi] <= s3_q[gi];
               end
               prv_q[gi] <= lvl_q[gi];
            end
         end
      end
   endgenerate

   wire [4:0] rise = lvl_q & ~prv_q; // accepted rising edges
   wire [4:0] fall = ~lvl_q & prv_q; // accepted falling edges
   wire sel = ~lvl_q[`IPR_PIN_CS]; // chip selected
   wire sdi = lvl_q[`IPR_PIN_SDI]; // serial data level

   // ==================================================
   // registers
   reg [7:0] ub_q; // upper impedance bound, as conductance code
   reg [7:0] lb_q; // lower impedance bound, as conductance code
   reg [15:0] thi_q; // high threshold
   reg [15:0] tlo_q; // low threshold
   reg [1:0] mode_q; // interrupt pin mode
   reg [15:0] prox_q; // proximity result
   reg [23:0] freq_q; // frequency count result

   // read decode of the register map
   function [7:0] reg_read;
      input [6:0] a;
      begin
         case (a)
            `IPR_ADDR_ID: reg_read = `IPR_ID_VALUE;
            `IPR_ADDR_UB: reg_read = ub_q;
            `IPR_ADDR_LB: reg_read = lb_q;
            `IPR_ADDR_THI_L: reg_read = thi_q[7:0];
            `IPR_ADDR_THI_H: reg_read = thi_q[15:8];
            `IPR_ADDR_TLO_L: reg_read = tlo_q[7:0];
            `IPR_ADDR_TLO_H: reg_read = tlo_q[15:8];
            `IPR_ADDR_MODE: reg_read = {6'h00, mode_q};
            `IPR_ADDR_PRX_L: reg_read = prox_q[7:0];
            `IPR_ADDR_PRX_H: reg_read = prox_q[15:8];
            `IPR_ADDR_FRQ_0: reg_read = freq_q[7:0];
            `IPR_ADDR_FRQ_1: reg_read = freq_q[15:8];
            `IPR_ADDR_FRQ_2: reg_read = freq_q[23:16];
            default: reg_read = 8'h00;
         endcase
      end
   endfunction

   // ==================================================
   // serial slave: sample on clock rise, shift out on clock fall
   reg [2:0] bit_q; // bit within byte
   reg cmd_done_q; // command byte received
   reg rw_q; // access direction, 1 = read
   reg [6:0] addr_q; // current register address
   reg [7:0] sh_q; // receive shift
   reg [7:0] tx_q; // transmit shift
   reg sdo_q; // serial data out
   reg oe_q; // serial data out enable

   wire byte_end = sel && rise[`IPR_PIN_SCLK] && (bit_q == `IPR_BYTE_LAST);
   wire [7:0] byte_in = {sh_q[6:0], sdi};
   wire wr_fire = byte_end && cmd_done_q && !rw_q; // data byte to write
   wire rd_hit = byte_end && !cmd_done_q && byte_in[7]
      && (byte_in[6:0] == `IPR_ADDR_PRX_L); // read of result low byte

   // command, address increment and data shifting
   always @(posedge clk) begin
      if (!rst_n) begin
         bit_q <= 3'h0;
         cmd_done_q <= 1'b0;
         rw_q <= 1'b0;
         addr_q <= 7'h00;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (!sel) begin
         // each new select starts a new access
         bit_q <= 3'h0;
         cmd_done_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= cmd_done_q && rw_q;
         if (rise[`IPR_PIN_SCLK]) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (byte_end && !cmd_done_q) begin
               // msb selects direction, rest is the address
               cmd_done_q <= 1'b1;
               rw_q <= byte_in[7];
               if (byte_in[7]) begin
                  tx_q <= reg_read(byte_in[6:0]);
                  addr_q <= byte_in[6:0] + 7'h01;
               end else begin
                  addr_q <= byte_in[6:0];
               end
            end else if (byte_end) begin
               // extended access walks the addresses
               addr_q <= addr_q + 7'h01;
               if (rw_q) begin
                  tx_q <= reg_read(addr_q);
               end
            end
         end else if (fall[`IPR_PIN_SCLK] && cmd_done_q && rw_q) begin
            sdo_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // ==================================================
   // writable registers; writes to read-only addresses are dropped
   always @(posedge clk) begin
      if (!rst_n) begin
         ub_q <= `IPR_RST_UB;
         lb_q <= `IPR_RST_LB;
         thi_q <= `IPR_RST_THI;
         tlo_q <= `IPR_RST_TLO;
         mode_q <= `IPR_RST_MODE;
      end else if (wr_fire) begin
         case (addr_q)
            `IPR_ADDR_UB: ub_q <= byte_in;
            `IPR_ADDR_LB: lb_q <= byte_in;
            `IPR_ADDR_THI_L: thi_q[7:0] <= byte_in;
            `IPR_ADDR_THI_H: thi_q[15:8] <= byte_in;
            `IPR_ADDR_TLO_L: tlo_q[7:0] <= byte_in;
            `IPR_ADDR_TLO_H: tlo_q[15:8] <= byte_in;
            `IPR_ADDR_MODE: mode_q <= byte_in[1:0];
            default: ;
         endcase
      end
   end

   // ==================================================
   // conversion: a fixed number of sensor periods, timebase edges counted
   reg [7:0] per_q; // sensor periods in this conversion
   reg [23:0] tb_q; // timebase edges in this conversion
   reg [15:0] pwr_q; // power code captured at conversion end
   reg conv_end_q; // one-cycle conversion end pulse

   wire [23:0] tb_next = (rise[`IPR_PIN_TB] && tb_q != `IPR_TB_MAX) ?
      (tb_q + 24'h000001) : tb_q;

   // period counting and result capture
   always @(posedge clk) begin
      if (!rst_n) begin
         per_q <= 8'h00;
         tb_q <= 24'h000000;
         freq_q <= 24'h000000;
         pwr_q <= 16'h0000;
         conv_end_q <= 1'b0;
      end else begin
         conv_end_q <= 1'b0;
         if (rise[`IPR_PIN_SENS] && per_q == `IPR_RESP_LAST) begin
            // both results taken at the same edge
            per_q <= 8'h00;
            tb_q <= 24'h000000;
            freq_q <= tb_next; // higher frequency, fewer edges
            pwr_q <= conv_power;
            conv_end_q <= 1'b1;
         end else begin
            if (rise[`IPR_PIN_SENS]) begin
               per_q <= per_q + 8'h01;
            end
            tb_q <= tb_next;
         end
      end
   end

   // ==================================================
   // impedance mapping: (g - g_upper) * 2^15 / (g_lower - g_upper)
   wire [15:0] g_up = {ub_q, 8'h00}; // conductance at upper bound
   wire [15:0] g_lo = {lb_q, 8'h00}; // conductance at lower bound
   wire clip = (pwr_q >= g_lo) || (g_lo <= g_up);
   wire floor0 = (pwr_q <= g_up); // at or above upper bound
   wire [15:0] span = g_lo - g_up;
   wire [15:0] offs = pwr_q - g_up;
   wire div_go = conv_end_q && !clip && !floor0;
   wire div_done;
   wire [15:0] div_quo;

   // power rises as impedance falls, so code falls with impedance
   ipr_ratio_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .start(div_go),
      .num({offs, `IPR_FRAC_ZERO}),
      .den(span),
      .done(div_done),
      .quo(div_quo)
   );

   wire res_fire = div_done || (conv_end_q && (clip || floor0));
   wire [15:0] res_val = div_done ? div_quo :
      (clip ? `IPR_FULL_SCALE : 16'h0000);

   // result register
   always @(posedge clk) begin
      if (!rst_n) begin
         prox_q <= 16'h0000;
      end else if (res_fire) begin
         prox_q <= res_val;
      end
   end

   // ==================================================
   // interrupt pin functions
   reg irq_q; // asserted state
   reg irq_n_q; // pin level, active low

   // new result events set, reads and mode writes clear; a mode write wins over a set, a set over a read
   always @(posedge clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~irq_q;
         if (wr_fire && addr_q == `IPR_ADDR_MODE) begin
            // any write of the mode register releases the pin
            irq_q <= 1'b0;
         end else begin
            case (mode_q)
               `IPR_MODE_COMP: begin
                  if (res_fire && res_val > thi_q) begin
                     irq_q <= 1'b1;
                  end else if (res_fire && res_val < tlo_q) begin
                     irq_q <= 1'b0;
                  end
               end
               `IPR_MODE_WAKE: begin
                  if (res_fire && res_val > thi_q) begin
                     irq_q <= 1'b1;
                  end
               end
               `IPR_MODE_RDY: begin
                  if (res_fire) begin
                     irq_q <= 1'b1;
                  end else if (rd_hit || rise[`IPR_PIN_SENS]) begin
                     irq_q <= 1'b0;
                  end
               end
               default: begin
                  irq_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==================================================
   // outputs straight from flops
   assign serial_out = sdo_q;
   assign serial_out_en = oe_q;
   assign interrupt_out_n = irq_n_q;

endmodule // ipr_readout
`default_nettype wire

//--- ipr_host_model.sv
// ipr_host_model.sv: behavioural serial master standing in for the host.
// Assumes mode 0 framing, a 160 ns serial clock and one command at a time.
`timescale 1ns/1ps
`default_nettype none

module ipr_host_model (
   // serial lines toward the device
   output logic select_low,
   output logic serial_clk,
   output logic serial_in,
   // answer from the device
   input wire logic serial_out,
   input wire logic serial_out_en
);
   // ==============================================
   // idle levels: clock parked low, not selected
   initial begin
      select_low = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end

   // ==============================================
   // one frame: command byte then two data bytes, msb first
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
      logic [23:0] tx;
      int i;
      tx = {cmd, wd};
      rd = 16'h0000;
      #7;
      select_low = 1'b0;
      for (i = 23; i >= 0; i--) begin
         serial_in = tx[i];
         #80;
         serial_clk = 1'b1;
         #80;
         // sample late in the high phase; an undriven line reads inverted
         if (i < 16) rd[i] = serial_out_en ? serial_out : ~serial_out;
         serial_clk = 1'b0;
      end
      #80;
      select_low = 1'b1;
      serial_in = ~serial_in; // released data line does not hold its value
      #200;
   endtask
endmodule // ipr_host_model

`default_nettype wire

//--- ipr_readout_asserts.sv
// ipr_readout_asserts.sv: port-level checker of the proximity readout.
// Assumes it is bound to ipr_readout and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ipr_readout_chk (
   // system
   input wire logic clk,
   input wire logic rst_n,
   // serial port and interrupt pin
   input wire logic select_low,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic interrupt_out_n
);
   // ==============================================
   // frame tracking from the raw pins
   logic sclk_q; // serial clock one cycle ago
   logic [7:0] rises_q; // serial clock rises in this frame
   logic [7:0] shift_q; // incoming command bits
   logic [7:0] cmd_q; // command byte of the last frame
   always @(posedge clk) begin
      sclk_q <= serial_clk;
      if (select_low) begin
         rises_q <= 8'h00;
      end else if (serial_clk && !sclk_q && rises_q != 8'hFF) begin
         rises_q <= rises_q + 8'h01;
         shift_q <= {shift_q[6:0], serial_in};
         if (rises_q == 8'h07) cmd_q <= {shift_q[6:0], serial_in};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==============================================
   // assertions
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rst_n |=> !serial_out_en && !serial_out && interrupt_out_n) else $error("outputs not idle");
   chk_irq_after_rst: assert property ($rose(rst_n) |-> interrupt_out_n [*8])
      else $error("interrupt without a result");
   chk_en_after_cmd: assert property ($rose(serial_out_en) |->
      !select_low && rises_q == 8'h08) else $error("drive not after eighth rise");
   chk_read_only_en: assert property (serial_out_en |-> cmd_q[7])
      else $error("drive on a write command");
   chk_en_holds: assert property (serial_out_en && !select_low && rises_q >= 8'h02
      |=> serial_out_en) else $error("drive dropped in frame");
   chk_en_drops: assert property (select_low [*8] |=> !serial_out_en)
      else $error("drive while not selected");
   chk_en_fall_cause: assert property ($fell(serial_out_en) |-> $past(select_low, 2))
      else $error("drive fell while selected");
   chk_out_after_fall: assert property (serial_out_en && $changed(serial_out)
      |-> !$past(serial_clk, 3)) else $error("data moved outside clock low phase");

   // ==============================================
   // covers of the main scenarios
   cov_read: cover property ($rose(serial_out_en));
   cov_write: cover property (rises_q == 8'h10 && !cmd_q[7]);
   cov_irq_set: cover property ($fell(interrupt_out_n));
   cov_irq_clr: cover property ($rose(interrupt_out_n));
endmodule // ipr_readout_chk

bind ipr_readout ipr_readout_chk u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .select_low(select_low),
   .serial_clk(serial_clk),
   .serial_in(serial_in),
   .serial_out(serial_out),
   .serial_out_en(serial_out_en),
   .interrupt_out_n(interrupt_out_n)
);

`default_nettype wire

//--- ipr_readout_tb_top.sv
// ipr_readout_tb_top.sv: self-checking bench of the proximity readout.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end

module ipr_readout_tb_top;
   // ==============================================
   // pins, clocks and bookkeeping
   logic clk = 1'b0; // 50 MHz system clock
   logic rst_n = 1'b0; // synchronous reset
   logic sensor_osc_in = 1'b0; // resonator, 2 MHz
   logic timebase_clock_in = 1'b0; // timebase, 4 MHz
   logic [15:0] conv_power = 16'h0000; // amplitude loop code
   wire select_low, serial_clk, serial_in, serial_out, serial_out_en, interrupt_out_n;
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 32'h6C05A116;
   int ub = 32'h0E; // model of the upper bound register
   int lb = 32'h14; // model of the lower bound register
   int i, w;
   logic [15:0] rd; // data of the last burst
   always #10 clk = ~clk;
   always #250 sensor_osc_in = ~sensor_osc_in;
   always #125 timebase_clock_in = ~timebase_clock_in;

   ipr_host_model u_host (.select_low(select_low), .serial_clk(serial_clk),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));
   ipr_readout u_dut (.clk(clk), .rst_n(rst_n), .select_low(select_low),
      .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .sensor_osc_in(sensor_osc_in),
      .timebase_clock_in(timebase_clock_in), .conv_power(conv_power),
      .interrupt_out_n(interrupt_out_n));

   // ==============================================
   // reference model of the proximity code
   function automatic logic [15:0] prox_model(input int p);
      int gu, gl;
      gu = ub * 256;
      gl = lb * 256;
      if (p >= gl || gl <= gu) return 16'hFFFF;
      if (p <= gu) return 16'h0000;
      return ((p - gu) * 32768) / (gl - gu);
   endfunction

   task automatic test_done;
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // bounded wait for a pin level; running out ends the run
   task automatic wait_irq(input logic lvl, input int bound);
      for (w = 0; w < bound && interrupt_out_n !== lvl; w++) @(negedge clk);
      if (interrupt_out_n !== lvl) begin
         n_mismatch++;
         $display("FAIL irq wait exp %h got %h", lvl, interrupt_out_n);
         test_done();
      end
   endtask

   // pin must still sit at a level after a full conversion
   task automatic hold_chk(input logic lvl);
      repeat (5000) @(negedge clk);
      `CHK("irq hold", lvl, interrupt_out_n)
   endtask

   task automatic pwr(input logic [15:0] p);
      @(negedge clk);
      conv_power = p;
   endtask

   task automatic set_mode(input logic [7:0] m);
      u_host.xfer(8'h0A, {m, 8'h00}, rd); // second byte hits an unmapped place
   endtask

   // one conversion in ready mode: clip high, clip low, then random codes
   task automatic run_prox(input int k);
      int p;
      if (k == 0) p = lb * 256;
      else if (k == 1) p = ub * 256;
      else p = ub * 256 + $unsigned($random(seed)) % ((lb - ub) * 256);
      pwr(p[15:0]);
      u_host.xfer(8'hA1, 16'h0000, rd); // drop any older ready flag
      wait_irq(1'b0, 6000);
      u_host.xfer(8'hA1, 16'h0000, rd);
      `CHK("prox", prox_model(p), {rd[7:0], rd[15:8]})
   endtask

   // ==============================================
   // main sequence
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      u_host.xfer(8'h80, 16'h0000, rd);
      `CHK("id and upper", {`IPR_ID_VALUE, `IPR_RST_UB}, rd)
      for (i = 0; i < 4; i++) run_prox(i);
      u_host.xfer(8'h01, 16'h1018, rd); // wider bound window
      ub = 32'h10;
      lb = 32'h18;
      u_host.xfer(8'h21, 16'hFFFF, rd); // result bytes are read-only
      u_host.xfer(8'h81, 16'h0000, rd);
      `CHK("bounds", 16'h1018, rd)
      for (i = 0; i < 3; i++) run_prox(i);
      u_host.xfer(8'hA3, 16'h0000, rd);
      w = {rd[7:0], rd[15:8]};
      `CHK("freq", 1'b1, w >= 383 && w <= 385)
      // unread results keep pulsing the pin
      wait_irq(1'b0, 6000);
      for (w = 0; w < 100 && interrupt_out_n === 1'b0; w++) @(negedge clk);
      `CHK("pulse width", 1'b1, w > 0 && w <= 30)
      wait_irq(1'b0, 6000);
      // comparator with 0x5000 high and 0x2000 low thresholds
      u_host.xfer(8'h06, 16'h0050, rd);
      u_host.xfer(8'h08, 16'h0020, rd);
      set_mode(8'h02);
      pwr(16'h1600);
      wait_irq(1'b0, 6000);
      pwr(16'h1300);
      hold_chk(1'b0);
      pwr(16'h1100);
      wait_irq(1'b1, 6000);
      // wake mode holds until the mode register is written
      set_mode(8'h01);
      pwr(16'h1600);
      wait_irq(1'b0, 6000);
      pwr(16'h1100);
      hold_chk(1'b0);
      set_mode(8'h01);
      wait_irq(1'b1, 50);
      // pin off
      pwr(16'h1600);
      set_mode(8'h00);
      hold_chk(1'b1);
      test_done();
   end
endmodule // ipr_readout_tb_top

`default_nettype wire
